// [hdl/cond_branch_and_shift_exec.sv]
// execution of conditional branches, shifts, flag and io bit operations
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - branch_flag_clear jumps to pc+offset+1 on selected flag zero; 1/2 cycles.
// - branch_equal jumps on zero flag one, branch_not_equal on it zero.
// - carry set/lower jump on carry one; clear/same-higher on carry zero.
// - branch_minus jumps on negative flag one, branch_plus on it zero.
// - ge_signed jumps when negative xor overflow is zero, lt_signed when one.
// - half_set jumps on half carry one, half_clear on half carry zero.
// - user_bit_set jumps on user flag one, user_bit_clear on zero.
// - ovf_set jumps on overflow one, ovf_clear on overflow zero.
// - irq_on/off test global enable flag; branches never change any flag.
// - left shift in one cycle, zero into bit 0, updates Z C N V H.
// - logical right shift, zero into bit 7, updates Z C N V, keeps H.
// - rotate left through carry, old bit 7 to carry, updates Z C N V H.
// - rotate right through carry, old bit 0 to carry, updates Z C N V.
// - arithmetic right shift keeps msb, updates Z C N V.
// - nibble exchange swaps register halves in one cycle, flags untouched.
// - flag set/clear forces only the selected status bit, one cycle.
// - io bit set raises one io bit, others and flags untouched.
module cond_branch_and_shift_exec (
    // clock and reset
    input  wire logic                            i_clock,
    input  wire logic                            i_reset_n,
    // request from fetch/decode
    input  wire logic                            i_valid,
    input  wire branch_shift_pkg::exec_req_t     i_req,
    output logic                                 o_ready,
    output logic                                 o_done,
    // status flags from the rest of the core
    input  wire logic                            i_flag_load,
    input  wire logic [branch_shift_pkg::DATA_W-1:0] i_flag_data,
    output logic [branch_shift_pkg::DATA_W-1:0]  o_flags,
    // program counter update
    output logic                                 o_pc_load,
    output logic [branch_shift_pkg::PC_W-1:0]    o_pc_value,
    // register and io write-back
    output branch_shift_pkg::write_back_t        o_wb
);
    import branch_shift_pkg::*;

    exec_state_t       state_r;
    exec_state_t       state_nxt;
    logic [DATA_W-1:0] flags_r;
    logic [DATA_W-1:0] flags_nxt;
    logic [PC_W-1:0]   target_r;
    logic              done_r;
    logic              pc_load_r;
    logic [PC_W-1:0]   pc_value_r;
    write_back_t       wb_r;
    write_back_t       wb_nxt;

    // request decode
    wire logic accept = i_valid && (state_r == ST_IDLE);
    wire op_t  op     = i_req.op;

    wire logic flag_c = flags_r[FLAG_C];
    wire logic flag_z = flags_r[FLAG_Z];
    wire logic flag_n = flags_r[FLAG_N];
    wire logic flag_v = flags_r[FLAG_V];
    wire logic flag_h = flags_r[FLAG_H];
    wire logic flag_t = flags_r[FLAG_T];
    wire logic flag_i = flags_r[FLAG_I];
    wire logic flag_sel = flags_r[i_req.sel];

    // relative target, offset sign-extended so back jumps work
    wire logic [PC_W-1:0] offset_ext =
        {{(PC_W-OFF_W){i_req.offset[OFF_W-1]}}, i_req.offset};
    wire logic [PC_W-1:0] branch_target =
        i_req.pc + offset_ext + PC_STEP;

    // branch condition per opcode
    logic is_branch;
    logic branch_cond;
    always_comb begin
        is_branch   = 1'b1;
        branch_cond = 1'b0;
        case (op)
            OP_BRANCH_FLAG_CLEAR:  branch_cond = !flag_sel;
            OP_BRANCH_EQUAL:       branch_cond = flag_z;
            OP_BRANCH_NOT_EQUAL:   branch_cond = !flag_z;
            OP_BRANCH_CARRY_SET,
            OP_BRANCH_LOWER:       branch_cond = flag_c;
            OP_BRANCH_CARRY_CLEAR,
            OP_BRANCH_SAME_HIGHER: branch_cond = !flag_c;
            OP_BRANCH_MINUS:       branch_cond = flag_n;
            OP_BRANCH_PLUS:        branch_cond = !flag_n;
            OP_BRANCH_GE_SIGNED:   branch_cond = !(flag_n ^ flag_v);
            OP_BRANCH_LT_SIGNED:   branch_cond = flag_n ^ flag_v;
            OP_BRANCH_HALF_SET:    branch_cond = flag_h;
            OP_BRANCH_HALF_CLEAR:  branch_cond = !flag_h;
            OP_BRANCH_USER_SET:    branch_cond = flag_t;
            OP_BRANCH_USER_CLEAR:  branch_cond = !flag_t;
            OP_BRANCH_OVF_SET:     branch_cond = flag_v;
            OP_BRANCH_OVF_CLEAR:   branch_cond = !flag_v;
            OP_BRANCH_IRQ_ON:      branch_cond = flag_i;
            OP_BRANCH_IRQ_OFF:     branch_cond = !flag_i;
            default:               is_branch   = 1'b0;
        endcase
    end

    wire logic take_branch = accept && is_branch && branch_cond;

    // shift and rotate datapath
    wire logic [DATA_W-1:0] d  = i_req.rd_data;
    wire logic              d_msb = d[MSB_POS];
    wire logic              d_lsb = d[0];

    logic [DATA_W-1:0] sh_res;
    logic              sh_carry;
    logic              sh_is_left;
    logic              is_shift;
    always_comb begin
        sh_res     = d;
        sh_carry   = flag_c;
        sh_is_left = 1'b0;
        is_shift   = 1'b1;
        case (op)
            OP_SHIFT_LEFT_LOGICAL: begin
                sh_res     = {d[DATA_W-2:0], 1'b0};
                sh_carry   = d_msb;
                sh_is_left = 1'b1;
            end
            OP_SHIFT_RIGHT_LOGIC: begin
                sh_res   = {1'b0, d[DATA_W-1:1]};
                sh_carry = d_lsb;
            end
            OP_ROTATE_LEFT_CARRY: begin
                sh_res     = {d[DATA_W-2:0], flag_c};
                sh_carry   = d_msb;
                sh_is_left = 1'b1;
            end
            OP_ROTATE_RIGHT_CARRY: begin
                sh_res   = {flag_c, d[DATA_W-1:1]};
                sh_carry = d_lsb;
            end
            OP_SHIFT_RIGHT_ARITH: begin
                sh_res   = {d_msb, d[DATA_W-1:1]};
                sh_carry = d_lsb;
            end
            default: is_shift = 1'b0;
        endcase
    end

    // shift flags; overflow is sign xor new carry as for all shifts
    wire logic sh_z = (sh_res == '0);
    wire logic sh_n = sh_res[MSB_POS];
    wire logic sh_v = sh_n ^ sh_carry;
    // half carry out of bit 3 only exists for the left moves
    wire logic sh_h = sh_is_left ? d[HALF_POS] : flag_h;

    wire logic [DATA_W-1:0] swapped =
        {d[NIB_W-1:0], d[DATA_W-1:NIB_W]};

    // one-hot mask for flag and io bit selection
    wire logic [DATA_W-1:0] sel_mask = DATA_W'(1) << i_req.sel;

    // next flag value; branches, swap and io ops leave flags alone
    always_comb begin
        flags_nxt = flags_r;
        if (i_flag_load) begin
            flags_nxt = i_flag_data;
        end
        if (accept) begin
            case (op)
                OP_FLAG_BIT_SET:   flags_nxt = flags_r | sel_mask;
                OP_FLAG_BIT_CLEAR: flags_nxt = flags_r & ~sel_mask;
                default: begin
                    if (is_shift) begin
                        flags_nxt         = flags_r;
                        flags_nxt[FLAG_Z] = sh_z;
                        flags_nxt[FLAG_C] = sh_carry;
                        flags_nxt[FLAG_N] = sh_n;
                        flags_nxt[FLAG_V] = sh_v;
                        flags_nxt[FLAG_H] = sh_h;
                    end
                end
            endcase
        end
    end

    // write-back selection
    always_comb begin
        wb_nxt         = '0;
        wb_nxt.io_addr = i_req.io_addr;
        if (accept) begin
            if (is_shift) begin
                wb_nxt.rd_we   = 1'b1;
                wb_nxt.rd_data = sh_res;
            end else if (op == OP_NIBBLE_EXCHANGE) begin
                wb_nxt.rd_we   = 1'b1;
                wb_nxt.rd_data = swapped;
            end else if (op == OP_IO_BIT_SET) begin
                wb_nxt.io_we   = 1'b1;
                wb_nxt.io_data = i_req.io_rdata | sel_mask;
            end
        end
    end

    // taken branch spends one extra cycle before the pc is loaded
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (take_branch) begin
                    state_nxt = ST_BRANCH;
                end
            end
            ST_BRANCH: state_nxt = ST_IDLE;
            default:   state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_r <= ST_IDLE;
            flags_r <= FLAGS_RST;
        end else begin
            state_r <= state_nxt;
            flags_r <= flags_nxt;
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            target_r <= PC_RST;
        end else if (take_branch) begin
            target_r <= branch_target;
        end
    end

    // not-taken and one-cycle ops finish at once, taken branch a cycle later
    wire logic done_nxt = (accept && !take_branch) ||
                          (state_r == ST_BRANCH);
    wire logic pc_load_nxt = (state_r == ST_BRANCH);

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            done_r     <= 1'b0;
            pc_load_r  <= 1'b0;
            pc_value_r <= PC_RST;
            wb_r       <= '0;
        end else begin
            done_r    <= done_nxt;
            pc_load_r <= pc_load_nxt;
            wb_r      <= wb_nxt;
            if (pc_load_nxt) begin
                pc_value_r <= target_r;
            end
        end
    end

    assign o_ready    = (state_r == ST_IDLE);
    assign o_done     = done_r;
    assign o_flags    = flags_r;
    assign o_pc_load  = pc_load_r;
    assign o_pc_value = pc_value_r;
    assign o_wb       = wb_r;

endmodule // cond_branch_and_shift_exec
`default_nettype wire

// [include/branch_shift_pkg.sv]
// shared types and constants for the branch and shift execution slice
`default_nettype none
package branch_shift_pkg;
    // widths
    localparam int PC_W   = 16;
    localparam int OFF_W  = 7;
    localparam int IOA_W  = 6;
    localparam int DATA_W = 8;
    localparam int SEL_W  = 3;

    // status bit positions inside cpu_flag_reg
    localparam logic [SEL_W-1:0] FLAG_C = 3'h0;
    localparam logic [SEL_W-1:0] FLAG_Z = 3'h1;
    localparam logic [SEL_W-1:0] FLAG_N = 3'h2;
    localparam logic [SEL_W-1:0] FLAG_V = 3'h3;
    localparam logic [SEL_W-1:0] FLAG_S = 3'h4;
    localparam logic [SEL_W-1:0] FLAG_H = 3'h5;
    localparam logic [SEL_W-1:0] FLAG_T = 3'h6;
    localparam logic [SEL_W-1:0] FLAG_I = 3'h7;

    // data bit positions used by the shifts
    localparam int MSB_POS  = DATA_W - 1;
    localparam int HALF_POS = 3;
    localparam int NIB_W    = 4;

    // reset values and branch pc step
    localparam logic [DATA_W-1:0] FLAGS_RST = 8'h00;
    localparam logic [PC_W-1:0]   PC_RST    = 16'h0000;
    localparam logic [PC_W-1:0]   PC_STEP   = 16'h0001;

    // operations handled by this slice
    typedef enum logic [4:0] {
        OP_NONE               = 5'h00,
        OP_BRANCH_FLAG_CLEAR  = 5'h01,
        OP_BRANCH_EQUAL       = 5'h02,
        OP_BRANCH_NOT_EQUAL   = 5'h03,
        OP_BRANCH_CARRY_SET   = 5'h04,
        OP_BRANCH_CARRY_CLEAR = 5'h05,
        OP_BRANCH_SAME_HIGHER = 5'h06,
        OP_BRANCH_LOWER       = 5'h07,
        OP_BRANCH_MINUS       = 5'h08,
        OP_BRANCH_PLUS        = 5'h09,
        OP_BRANCH_GE_SIGNED   = 5'h0a,
        OP_BRANCH_LT_SIGNED   = 5'h0b,
        OP_BRANCH_HALF_SET    = 5'h0c,
        OP_BRANCH_HALF_CLEAR  = 5'h0d,
        OP_BRANCH_USER_SET    = 5'h0e,
        OP_BRANCH_USER_CLEAR  = 5'h0f,
        OP_BRANCH_OVF_SET     = 5'h10,
        OP_BRANCH_OVF_CLEAR   = 5'h11,
        OP_BRANCH_IRQ_ON      = 5'h12,
        OP_BRANCH_IRQ_OFF     = 5'h13,
        OP_SHIFT_LEFT_LOGICAL = 5'h14,
        OP_SHIFT_RIGHT_LOGIC  = 5'h15,
        OP_ROTATE_LEFT_CARRY  = 5'h16,
        OP_ROTATE_RIGHT_CARRY = 5'h17,
        OP_SHIFT_RIGHT_ARITH  = 5'h18,
        OP_NIBBLE_EXCHANGE    = 5'h19,
        OP_FLAG_BIT_SET       = 5'h1a,
        OP_FLAG_BIT_CLEAR     = 5'h1b,
        OP_IO_BIT_SET         = 5'h1c
    } op_t;

    // one request from fetch/decode
    typedef struct packed {
        op_t               op;
        logic [SEL_W-1:0]  sel;
        logic [DATA_W-1:0] rd_data;
        logic [OFF_W-1:0]  offset;
        logic [IOA_W-1:0]  io_addr;
        logic [DATA_W-1:0] io_rdata;
        logic [PC_W-1:0]   pc;
    } exec_req_t;

    // register and io write-back
    typedef struct packed {
        logic              rd_we;
        logic [DATA_W-1:0] rd_data;
        logic              io_we;
        logic [IOA_W-1:0]  io_addr;
        logic [DATA_W-1:0] io_data;
    } write_back_t;

    // execution states, one-hot
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b01,
        ST_BRANCH = 2'b10
    } exec_state_t;
endpackage
`default_nettype wire

// [test/branch_shift_asserts.sv]
// concurrent checks on the branch and shift execution ports
`timescale 1ns/1ps
`default_nettype none
module branch_shift_asserts (
    // clock and reset
    input wire logic                          i_clock,
    input wire logic                          i_reset_n,
    // request side
    input wire logic                          i_valid,
    input wire branch_shift_pkg::exec_req_t   i_req,
    input wire logic                          o_ready,
    input wire logic                          o_done,
    // flags and results
    input wire logic                          i_flag_load,
    input wire logic [7:0]                    i_flag_data,
    input wire logic [7:0]                    o_flags,
    input wire logic                          o_pc_load,
    input wire logic [15:0]                   o_pc_value,
    input wire branch_shift_pkg::write_back_t o_wb
);
    import branch_shift_pkg::*;
    wire take = i_valid && o_ready;
    wire br   = take &&
        (i_req.op inside {[OP_BRANCH_FLAG_CLEAR:OP_BRANCH_IRQ_OFF]});
    wire [15:0] tgt =
        i_req.pc + {{9{i_req.offset[6]}}, i_req.offset} + PC_STEP;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);

    a_taken_gap_pulse: assert property (
        !o_ready |=> o_ready && o_done && o_pc_load)
        else $error("ready gap not closed by a pc load");
    a_load_after_gap: assert property (
        o_pc_load |-> $past(!o_ready) && o_done)
        else $error("pc load without the gap cycle");
    a_eq_target_value: assert property (
        take && i_req.op == OP_BRANCH_EQUAL && o_flags[FLAG_Z]
        |=> !o_ready ##1 o_pc_value == $past(tgt, 2))
        else $error("wrong target");
    a_ne_not_taken: assert property (
        take && i_req.op == OP_BRANCH_NOT_EQUAL && o_flags[FLAG_Z]
        |=> o_done && !o_pc_load && o_ready)
        else $error("branch taken wrongly");
    a_branch_keeps_flags: assert property (
        br && !i_flag_load |=> o_flags == $past(o_flags))
        else $error("branch changed flags");
    a_left_out_bit: assert property (
        take && i_req.op == OP_SHIFT_LEFT_LOGICAL
        |=> o_done && o_wb.rd_we
        && o_wb.rd_data == {$past(i_req.rd_data[6:0]), 1'b0}
        && o_flags[FLAG_C] == $past(i_req.rd_data[7]))
        else $error("left shift wrong");
    a_right_keeps_half: assert property (
        take && i_req.op == OP_SHIFT_RIGHT_LOGIC
        |=> o_wb.rd_data == {1'b0, $past(i_req.rd_data[7:1])}
        && o_flags[FLAG_H] == $past(o_flags[FLAG_H])
        && o_flags[FLAG_C] == $past(i_req.rd_data[0]))
        else $error("right shift wrong");
    a_rotr_carry_in: assert property (
        take && i_req.op == OP_ROTATE_RIGHT_CARRY
        |=> o_wb.rd_data ==
        {$past(o_flags[FLAG_C]), $past(i_req.rd_data[7:1])})
        else $error("rotate wrong");
    a_arith_keeps_msb: assert property (
        take && i_req.op == OP_SHIFT_RIGHT_ARITH
        |=> o_wb.rd_data ==
        {$past(i_req.rd_data[7]), $past(i_req.rd_data[7:1])})
        else $error("arith shift wrong");
    a_swap_halves: assert property (
        take && i_req.op == OP_NIBBLE_EXCHANGE && !i_flag_load
        |=> o_wb.rd_data ==
        {$past(i_req.rd_data[3:0]), $past(i_req.rd_data[7:4])}
        && o_flags == $past(o_flags))
        else $error("swap wrong");
    a_io_one_bit: assert property (
        take && i_req.op == OP_IO_BIT_SET
        |=> o_wb.io_we && o_wb.io_data ==
        ($past(i_req.io_rdata) | (8'h01 << $past(i_req.sel))))
        else $error("io set wrong");
endmodule // branch_shift_asserts
bind cond_branch_and_shift_exec branch_shift_asserts u_chk (
    .i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_valid(i_valid), .i_req(i_req),
    .o_ready(o_ready), .o_done(o_done), .i_flag_load(i_flag_load),
    .i_flag_data(i_flag_data), .o_flags(o_flags), .o_pc_load(o_pc_load),
    .o_pc_value(o_pc_value), .o_wb(o_wb));
`default_nettype wire

// [test/pc_model.sv]
// program counter of the fetch stage, loaded by branch results
`timescale 1ns/1ps
`default_nettype none
module pc_model (
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_reset_n,
    // load from the branch slice
    input  wire logic        i_pc_load,
    input  wire logic [15:0] i_pc_value,
    output logic      [15:0] o_pc
);
    logic [15:0] pc_r;
    assign o_pc = pc_r;
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) pc_r <= 16'h0000;
        else if (i_pc_load) pc_r <= i_pc_value;
    end
endmodule // pc_model
`default_nettype wire

// [test/testbench.sv]
// directed bench for the branch and shift execution slice
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import branch_shift_pkg::*;
    logic        i_clock, i_reset_n, i_valid, i_flag_load;
    exec_req_t   i_req;
    logic [7:0]  i_flag_data, o_flags, fl;
    logic        o_ready, o_done, o_pc_load, tk;
    logic [15:0] o_pc_value, pc_now, pc_exp;
    logic [6:0]  off;
    write_back_t o_wb, wb_seen;
    int          miscompares, total_checks, cyc;
    op_t         sh_op [7] = '{OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_LEFT_LOGICAL,
        OP_SHIFT_RIGHT_LOGIC, OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY,
        OP_SHIFT_RIGHT_ARITH, OP_NIBBLE_EXCHANGE};
    // operand, flags in, result, flags out
    logic [31:0] sh_tab [7] = '{32'h81000209, 32'h80ff00db, 32'h0120002b,
        32'h4801912c, 32'h0201810c, 32'h8100c005, 32'ha55a5a5a};

    always #12.5 i_clock = ~i_clock;

    cond_branch_and_shift_exec u_dut (.i_clock(i_clock), .i_reset_n(i_reset_n),
        .i_valid(i_valid), .i_req(i_req), .o_ready(o_ready), .o_done(o_done),
        .i_flag_load(i_flag_load), .i_flag_data(i_flag_data),
        .o_flags(o_flags),
        .o_pc_load(o_pc_load), .o_pc_value(o_pc_value), .o_wb(o_wb));
    pc_model u_pc (.i_clock(i_clock), .i_reset_n(i_reset_n),
        .i_pc_load(o_pc_load), .i_pc_value(o_pc_value), .o_pc(pc_now));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic set_flags(input logic [7:0] f);
        @(negedge i_clock);
        i_flag_load = 1'b1;
        i_flag_data = f;
        @(negedge i_clock);
        i_flag_load = 1'b0;
    endtask

    // one request; fixed pc, io address and io read value
    task automatic run(input op_t op, input logic [2:0] sel,
                       input logic [7:0] rd, input logic [6:0] o);
        @(negedge i_clock);
        i_valid = 1'b1;
        i_req = '{op, sel, rd, o, 6'h15, 8'h5a, 16'h1000};
        @(negedge i_clock);
        i_valid = 1'b0;
        cyc = 1;
        while (o_done !== 1'b1 && cyc < 4) begin
            @(negedge i_clock);
            cyc++;
        end
        if (o_done !== 1'b1) begin
            chk(16'h0000, 16'h0001, "no done");
            end_of_test();
        end else wb_seen = o_wb;
    endtask

    function automatic logic want(input op_t op, input logic [7:0] f,
                                  input logic [2:0] s);
        case (op)
            OP_BRANCH_FLAG_CLEAR: want = !f[s];
            OP_BRANCH_EQUAL: want = f[FLAG_Z];
            OP_BRANCH_NOT_EQUAL: want = !f[FLAG_Z];
            OP_BRANCH_CARRY_SET, OP_BRANCH_LOWER: want = f[FLAG_C];
            OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_HIGHER: want = !f[FLAG_C];
            OP_BRANCH_MINUS: want = f[FLAG_N];
            OP_BRANCH_PLUS: want = !f[FLAG_N];
            OP_BRANCH_GE_SIGNED: want = !(f[FLAG_N] ^ f[FLAG_V]);
            OP_BRANCH_LT_SIGNED: want = f[FLAG_N] ^ f[FLAG_V];
            OP_BRANCH_HALF_SET: want = f[FLAG_H];
            OP_BRANCH_HALF_CLEAR: want = !f[FLAG_H];
            OP_BRANCH_USER_SET: want = f[FLAG_T];
            OP_BRANCH_USER_CLEAR: want = !f[FLAG_T];
            OP_BRANCH_OVF_SET: want = f[FLAG_V];
            OP_BRANCH_OVF_CLEAR: want = !f[FLAG_V];
            OP_BRANCH_IRQ_ON: want = f[FLAG_I];
            OP_BRANCH_IRQ_OFF: want = !f[FLAG_I];
            default: want = 1'b0;
        endcase
    endfunction

    initial begin
        i_clock = 1'b0;
        i_reset_n = 1'b0;
        i_valid = 1'b0;
        i_req = '0;
        i_flag_load = 1'b0;
        i_flag_data = 8'h00;
        miscompares = 0;
        total_checks = 0;
        repeat (6) @(posedge i_clock);
        @(negedge i_clock) i_reset_n = 1'b1;
        chk({8'h00, o_flags}, {8'h00, FLAGS_RST}, "reset flags");
        for (int k = 1; k <= 19; k++) begin
            for (int j = 0; j < 3; j++) begin
                fl = (j == 0) ? 8'h00 : (j == 1) ? 8'hff : 8'h08;
                off = k[0] ? 7'h40 : 7'h3f;
                tk = want(op_t'(k), fl, k[2:0]);
                set_flags(fl);
                run(op_t'(k), k[2:0], 8'h00, off);
                chk(16'(cyc), tk ? 16'h2 : 16'h1, "cyc");
                chk({8'h00, o_flags}, {8'h00, fl}, "bfl");
                if (tk) begin
                    @(negedge i_clock);
                    pc_exp = 16'h1001 + {{9{off[6]}}, off};
                    chk(pc_now, pc_exp, "pc");
                end
            end
        end
        $display("test branches done");
        for (int i = 0; i < 7; i++) begin
            set_flags(sh_tab[i][23:16]);
            run(sh_op[i], 3'h0, sh_tab[i][31:24], 7'h00);
            chk(16'(wb_seen.rd_data), 16'(sh_tab[i][15:8]), "d");
            chk(16'(wb_seen.rd_we), 16'h0001, "we");
            chk(16'(o_flags), 16'(sh_tab[i][7:0]), "f");
            chk(16'(cyc), 16'h0001, "shift cycles");
        end
        $display("test shifts done");
        for (int s = 0; s < 8; s++) begin
            set_flags(8'h00);
            run(OP_FLAG_BIT_SET, 3'(s), 8'h00, 7'h00);
            chk({8'h00, o_flags}, 16'h0001 << s, "flag set");
            set_flags(8'hff);
            run(OP_FLAG_BIT_CLEAR, 3'(s), 8'h00, 7'h00);
            chk({8'h00, o_flags}, {8'h00, ~(8'h01 << s)}, "clr");
        end
        $display("test flag bits done");
        for (int b = 0; b < 8; b += 7) begin
            set_flags(8'h00);
            run(OP_IO_BIT_SET, 3'(b), 8'h00, 7'h00);
            chk({wb_seen.io_addr, wb_seen.io_we, 1'b0, wb_seen.io_data},
                {6'h15, 1'b1, 1'b0, 8'h5a | (8'h01 << b)}, "io");
            chk({8'h00, o_flags}, 16'h0000, "io flags");
        end
        $display("test io bit done");
        end_of_test();
    end
endmodule // testbench
`default_nettype wire
